/* hdl/exc_defs.svh */
// Constants for the status word, modes, vectors and link offsets
`ifndef EXC_DEFS_SVH
`define EXC_DEFS_SVH
`define CTL_W 8
`define BIT_IMASK 7
`define BIT_FMASK 6
`define BIT_STATE 5
`define MODE_MSB 4
`define MODE_USR 5'h10
`define MODE_FIQ 5'h11
`define MODE_IRQ 5'h12
`define MODE_SVC 5'h13
`define MODE_ABT 5'h17
`define MODE_UND 5'h1B
`define MODE_SYS 5'h1F
`define CTL_RESET 8'hD3
`define VEC_RESET 32'h0000_0000
`define VEC_UND 32'h0000_0004
`define VEC_SWT 32'h0000_0008
`define VEC_PREFETCH_ABORT 32'h0000_000C
`define VEC_DATA_ABORT 32'h0000_0010
`define VEC_IRQ 32'h0000_0018
`define VEC_FIQ 32'h0000_001C
`define OFS_2 32'h0000_0002
`define OFS_4 32'h0000_0004
`define OFS_8 32'h0000_0008
`endif

/* hdl/exc_pkg.sv */
// Types for the exception entry and exit unit
package exc_pkg;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_ENTER = 2'b01,
    ST_LOCKED = 2'b11
  } core_state_t;
  typedef enum logic [2:0] {
    EX_NONE = 3'd0,
    EX_DATA_ABORT = 3'd1,
    EX_FIQ = 3'd2,
    EX_IRQ = 3'd3,
    EX_PREFETCH_ABORT = 3'd4,
    EX_UND = 3'd5,
    EX_SWT = 3'd6
  } exc_kind_t;
  typedef struct packed {
    logic imask;
    logic fmask;
    logic state;
    logic [4:0] mode;
  } ctl_t;
  typedef struct packed {
    logic valid;
    logic [31:0] pc;
  } pc_evt_t;
endpackage

/* hdl/exc_unit.sv */
// Status-word control bits, mode banking and exception entry/exit
//
// Functional notes
// [RULE_01] Low 8 status bits are control bits; set on entry, written only when privileged.
// [RULE_02] State bit set means compact 16-bit state; mirrored on the state output.
// [RULE_03] Normal mask blocks normal requests; fast mask blocks fast requests.
// [RULE_04] Mode codes: 10000 usr,10001 fiq,10010 irq,10011 svc,10111 abt,11011 und,11111 sys.
// [RULE_05] Only listed modes may be loaded; otherwise lock up until reset.
// [RULE_06] Fast mode banks r8-r14; irq/svc/abt/und bank r13,r14 and a saved word. The unit banks only the link (r14) and the saved word.
// [RULE_07] Software preserves reserved bits and does not rely on their value.
// [RULE_08] Software never writes the state bit of the current word directly.
// [RULE_09] Entry writes an offset return address into the target mode link register.
// [RULE_10] Entry copies the current status word into the target saved status word.
// [RULE_11] Entry forces the mode for the exception and fetches from its vector.
// [RULE_12] Entry may set interrupt masks to avoid unmanageable nesting.
// [RULE_13] Entry from compact state clears the state bit when loading the vector.
// [RULE_14] Return with restore copies the saved word into the current word.
// [RULE_15] Link: bl/trap/undef +4 or +2 compact; fiq/irq/prefetch_abort +4; data_abort +8.
// [RULE_16] Handlers return with link minus 4, minus 8, or unchanged as appropriate.
// [RULE_17] Supervisor link value after reset is undefined.
// [RULE_18] Requester raises a fast interrupt by holding the input low.
// [RULE_19] With sync select low both request inputs pass a synchroniser.
// [RULE_20] With fast mask clear, synchronised fast input is checked each instruction end.
// [RULE_21] User-mode writes to control bits are ignored.
// [RULE_22] Normal interrupt on low input, below fast, masked on fast entry.
// [RULE_23] Word-spaced vectors from zero; normal at 0x18, fast at 0x1C.
// [RULE_24] Priority: reset, data abort, fast, normal, prefetch abort, undef/trap.
// [RULE_25] After reset: mode 10011, both masks set, state clear, fetch from zero.
// [RULE_26] Fast entry sets both masks; other entries set only the normal mask.
`timescale 1ns/10ps
`include "exc_defs.svh"

module exc_unit (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic fast_request_n_i,
  input wire logic normal_request_n_i,
  input wire logic sync_select_input_i,
  input wire logic insn_end_i,
  input wire logic [31:0] pc_i,
  input wire logic data_abort_i,
  input wire logic prefetch_abort_i,
  input wire logic undefined_opcode_trap_i,
  input wire logic software_trap_i,
  input wire logic branch_with_link_i,
  input wire logic ctl_wr_i,
  input wire logic [7:0] ctl_wdata_i,
  input wire logic ret_restore_i,
  input wire logic [31:0] ret_link_i,
  output exc_pkg::pc_evt_t fetch_o,
  output exc_pkg::ctl_t ctl_o,
  output logic state_output_pin_o,
  output logic [31:0] exception_link_reg_o,
  output logic [7:0] saved_status_word_o,
  output logic locked_o
);
  import exc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic mode_legal(input logic [4:0] m);
    case (m)
      `MODE_USR, `MODE_FIQ, `MODE_IRQ, `MODE_SVC, `MODE_ABT, `MODE_UND, `MODE_SYS: mode_legal = 1'b1;
      default: mode_legal = 1'b0;
    endcase
  endfunction

  // Bank index: 0 none (usr/sys), 1 fiq, 2 irq, 3 svc, 4 abt, 5 und
  function automatic logic [2:0] bank_of(input logic [4:0] m);
    case (m)
      `MODE_FIQ: bank_of = 3'h1;
      `MODE_IRQ: bank_of = 3'h2;
      `MODE_SVC: bank_of = 3'h3;
      `MODE_ABT: bank_of = 3'h4;
      `MODE_UND: bank_of = 3'h5;
      default: bank_of = 3'h0;
    endcase
  endfunction

  // Return address: current address plus an offset, wrapping silently at the top of memory
  function automatic logic [31:0] link_after(input logic [31:0] pc, input logic [31:0] ofs);
    link_after = pc + ofs;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request sampling
  logic fiq_s1_r;
  logic fiq_s2_r;
  logic irq_s1_r;
  logic irq_s2_r;
  logic fiq_low;
  logic irq_low;

  // Flops reset to the idle high level, so no false request follows reset
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      fiq_s1_r <= 1'b1;
      fiq_s2_r <= 1'b1;
    end else begin
      fiq_s1_r <= fast_request_n_i;
      fiq_s2_r <= fiq_s1_r;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      irq_s1_r <= 1'b1;
      irq_s2_r <= 1'b1;
    end else begin
      irq_s1_r <= normal_request_n_i;
      irq_s2_r <= irq_s1_r;
    end
  end

  // Asynchronous requests take the two-stage path; synchronous ones are used directly
  assign fiq_low = sync_select_input_i ? !fast_request_n_i : !fiq_s2_r; // [RULE_19] [RULE_18]
  assign irq_low = sync_select_input_i ? !normal_request_n_i : !irq_s2_r; // [RULE_19] [RULE_22]

  ////////////////////////////////////////////////////////////////////////////
  // Exception selection
  ctl_t ctl_r;
  core_state_t st_r;
  exc_kind_t kind;

  always_comb begin
    kind = EX_NONE;
    if (data_abort_i) begin
      kind = EX_DATA_ABORT; // [RULE_24]
    end else if (insn_end_i && fiq_low && !ctl_r.fmask) begin
      kind = EX_FIQ; // [RULE_20] [RULE_03]
    end else if (insn_end_i && irq_low && !ctl_r.imask) begin
      kind = EX_IRQ; // [RULE_03] [RULE_22]
    end else if (prefetch_abort_i) begin
      kind = EX_PREFETCH_ABORT;
    end else if (undefined_opcode_trap_i) begin
      kind = EX_UND;
    end else if (software_trap_i) begin
      kind = EX_SWT;
    end
  end

  logic [4:0] tgt_mode;
  logic [31:0] tgt_vec;
  logic [31:0] tgt_link;
  logic [31:0] step;

  always_comb begin
    step = ctl_r.state ? `OFS_2 : `OFS_4; // [RULE_15] [RULE_09]
    tgt_mode = `MODE_SVC;
    tgt_vec = `VEC_SWT;
    tgt_link = link_after(pc_i, step);
    case (kind)
      EX_DATA_ABORT: begin
        tgt_mode = `MODE_ABT;
        tgt_vec = `VEC_DATA_ABORT;
        tgt_link = pc_i + `OFS_8; // [RULE_15]
      end
      EX_FIQ: begin
        tgt_mode = `MODE_FIQ;
        tgt_vec = `VEC_FIQ; // [RULE_23]
        tgt_link = pc_i + `OFS_4;
      end
      EX_IRQ: begin
        tgt_mode = `MODE_IRQ;
        tgt_vec = `VEC_IRQ; // [RULE_23]
        tgt_link = pc_i + `OFS_4;
      end
      EX_PREFETCH_ABORT: begin
        tgt_mode = `MODE_ABT;
        tgt_vec = `VEC_PREFETCH_ABORT;
        tgt_link = pc_i + `OFS_4;
      end
      EX_UND: begin
        tgt_mode = `MODE_UND; // [RULE_04]
        tgt_vec = `VEC_UND;
      end
      default: begin
        tgt_mode = `MODE_SVC;
        tgt_vec = `VEC_SWT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Banked link and saved status storage
  // Index 0 is the shared usr/sys link; usr/sys have no saved word
  logic [31:0] link_bank_r [0:5];
  logic [7:0] saved_bank_r [1:5];
  logic [2:0] cur_bank;
  logic [2:0] tgt_bank;
  logic entering;
  logic priv;

  assign cur_bank = bank_of(ctl_r.mode);
  assign tgt_bank = bank_of(tgt_mode);
  assign priv = ctl_r.mode != `MODE_USR;
  assign entering = (st_r == ST_RUN) && (kind != EX_NONE);

  always_ff @(posedge ref_clk_i) begin
    // Link bank has no reset: the supervisor link after reset is undefined by design
    if (nrst_i && entering) begin
      link_bank_r[tgt_bank] <= tgt_link; // [RULE_09] [RULE_06] [RULE_17]
    end else if (nrst_i && st_r == ST_RUN && branch_with_link_i) begin
      link_bank_r[cur_bank] <= link_after(pc_i, step); // [RULE_15]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      for (int i = 1; i <= 5; i++) begin
        saved_bank_r[i] <= 8'h00;
      end
      saved_bank_r[3] <= `CTL_RESET;
    end else if (entering) begin
      saved_bank_r[tgt_bank] <= ctl_r; // [RULE_10] [RULE_06]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current status control bits and core state
  logic ret_ok;
  ctl_t ctl_nxt;
  core_state_t st_nxt;

  // Restore is refused in usr/sys: they have no saved word to copy back
  assign ret_ok = ret_restore_i && (cur_bank != 3'h0);

  // Entry wins over restore, restore over a software write: one change per cycle
  always_comb begin
    ctl_nxt = ctl_r;
    st_nxt = st_r;
    case (st_r)
      ST_RUN: begin
        if (entering) begin
          ctl_nxt.mode = tgt_mode; // [RULE_11] [RULE_01]
          ctl_nxt.state = 1'b0; // [RULE_13]
          ctl_nxt.imask = 1'b1; // [RULE_12] [RULE_26]
          if (kind == EX_FIQ) begin
            ctl_nxt.fmask = 1'b1; // [RULE_26] [RULE_22]
          end
          st_nxt = ST_ENTER;
        end else if (ret_ok) begin
          ctl_nxt = saved_bank_r[cur_bank]; // [RULE_14]
          if (!mode_legal(saved_bank_r[cur_bank][`MODE_MSB:0])) begin
            st_nxt = ST_LOCKED; // [RULE_05]
          end
        end else if (ctl_wr_i && priv) begin
          // State bit left alone: software may not change it directly
          ctl_nxt.imask = ctl_wdata_i[`BIT_IMASK]; // [RULE_01] [RULE_21] [RULE_08]
          ctl_nxt.fmask = ctl_wdata_i[`BIT_FMASK];
          ctl_nxt.mode = ctl_wdata_i[`MODE_MSB:0];
          if (!mode_legal(ctl_wdata_i[`MODE_MSB:0])) begin
            st_nxt = ST_LOCKED; // [RULE_05] [RULE_04]
          end
        end
      end
      ST_ENTER: st_nxt = ST_RUN;
      // Only reset leaves the locked state; the illegal mode stays visible
      ST_LOCKED: st_nxt = ST_LOCKED;
      default: st_nxt = ST_LOCKED;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ctl_r <= `CTL_RESET; // [RULE_25]
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      st_r <= ST_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  // Status outputs lag the internal state by one cycle, so callers see settled values; fetch_o is loaded on the same edge as the state change
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      fetch_o <= '{valid: 1'b1, pc: `VEC_RESET}; // [RULE_25]
    end else if (entering) begin
      fetch_o <= '{valid: 1'b1, pc: tgt_vec}; // [RULE_11]
    end else if (st_r == ST_RUN && ret_ok) begin
      fetch_o <= '{valid: 1'b1, pc: ret_link_i}; // [RULE_16]
    end else begin
      fetch_o <= '{valid: 1'b0, pc: fetch_o.pc};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ctl_o <= `CTL_RESET;
      state_output_pin_o <= 1'b0;
    end else begin
      ctl_o <= ctl_r;
      state_output_pin_o <= ctl_r.state; // [RULE_02]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      locked_o <= 1'b0;
    end else begin
      locked_o <= st_r == ST_LOCKED;
    end
  end

  // Shows the reset value only until the first edge after reset; the bank itself is not reset
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      exception_link_reg_o <= 32'h0000_0000;
    end else begin
      exception_link_reg_o <= link_bank_r[cur_bank];
    end
  end

  // usr/sys read back zero: they have no saved word of their own
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      saved_status_word_o <= 8'h00;
    end else begin
      saved_status_word_o <= (cur_bank == 3'h0) ? 8'h00 : saved_bank_r[cur_bank];
    end
  end
endmodule // exc_unit

/* test/irq_src_model.sv */
// Interrupt controller model driving the active-low request lines
`timescale 1ns/10ps
module irq_src_model (
  input wire logic ref_clk_i,
  input wire logic fire_fast_i,
  input wire logic fire_normal_i,
  output logic fast_request_n_o,
  output logic normal_request_n_o
);
  // Requests are levels held low for as long as the source wants service
  always_ff @(posedge ref_clk_i) begin
    fast_request_n_o <= !fire_fast_i;
    normal_request_n_o <= !fire_normal_i;
  end
endmodule // irq_src_model

/* test/exc_unit_sva.sv */
// Concurrent checks on the exception unit ports
`timescale 1ns/10ps
`include "exc_defs.svh"
module exc_unit_sva (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic fast_request_n_i,
  input wire logic normal_request_n_i,
  input wire logic sync_select_input_i,
  input wire logic insn_end_i,
  input wire logic [31:0] pc_i,
  input wire logic data_abort_i,
  input wire logic prefetch_abort_i,
  input wire logic undefined_opcode_trap_i,
  input wire logic software_trap_i,
  input wire logic ctl_wr_i,
  input wire logic ret_restore_i,
  input wire exc_pkg::pc_evt_t fetch_o,
  input wire exc_pkg::ctl_t ctl_o,
  input wire logic state_output_pin_o,
  input wire logic [31:0] exception_link_reg_o,
  input wire logic [7:0] saved_status_word_o,
  input wire logic locked_o
);
  import exc_pkg::*;
  logic calm_r;
  // Output copy of the control bits lags by a cycle, so only trust it after a calm cycle
  always_ff @(posedge ref_clk_i) begin
    calm_r <= !ctl_wr_i && !ret_restore_i;
  end
  wire logic ok = calm_r && !fetch_o.valid && !locked_o && sync_select_input_i;
  wire logic no_ev = !data_abort_i && !prefetch_abort_i && !undefined_opcode_trap_i && !software_trap_i && !ret_restore_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_vec(logic [31:0] v);
    fetch_o.valid && fetch_o.pc == v;
  endsequence
  property p_rst;
    disable iff (1'b0) !nrst_i |=> ctl_o == `CTL_RESET && fetch_o.valid && fetch_o.pc == `VEC_RESET && !locked_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_data_abort;
    ok && data_abort_i |=> s_vec(`VEC_DATA_ABORT) ##1 ctl_o.mode == `MODE_ABT && ctl_o.imask && !ctl_o.state &&
      exception_link_reg_o == $past(pc_i, 2) + `OFS_8 && saved_status_word_o == $past(ctl_o);
  endproperty
  a_data_abort: assert property (p_data_abort) else $error("data abort entry wrong");
  property p_fiq;
    ok && !data_abort_i && insn_end_i && !fast_request_n_i && !ctl_o.fmask |=> s_vec(`VEC_FIQ) ##1
      ctl_o.mode == `MODE_FIQ && ctl_o.imask && ctl_o.fmask && exception_link_reg_o == $past(pc_i, 2) + `OFS_4;
  endproperty
  a_fiq: assert property (p_fiq) else $error("fast entry wrong");
  property p_irq;
    ok && !data_abort_i && insn_end_i && !normal_request_n_i && fast_request_n_i && !ctl_o.imask |=>
      s_vec(`VEC_IRQ) ##1 ctl_o.mode == `MODE_IRQ && ctl_o.imask && ctl_o.fmask == $past(ctl_o.fmask);
  endproperty
  a_irq: assert property (p_irq) else $error("normal entry wrong");
  property p_mask;
    ok && no_ev && ctl_o.fmask && ctl_o.imask |=> !fetch_o.valid;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request taken");
  property p_user;
    ok && no_ev && ctl_wr_i && ctl_o.mode == `MODE_USR && fast_request_n_i && normal_request_n_i |=> ##1 $stable(ctl_o);
  endproperty
  a_user: assert property (p_user) else $error("user write changed control bits");
  property p_lock;
    locked_o |=> locked_o;
  endproperty
  a_lock: assert property (p_lock) else $error("lock cleared without reset");
  property p_pin;
    state_output_pin_o == ctl_o.state;
  endproperty
  a_pin: assert property (p_pin) else $error("state pin differs");
endmodule // exc_unit_sva
bind exc_unit exc_unit_sva i_sva (.ref_clk_i, .nrst_i, .fast_request_n_i, .normal_request_n_i, .sync_select_input_i,
  .insn_end_i, .pc_i, .data_abort_i, .prefetch_abort_i, .undefined_opcode_trap_i, .software_trap_i, .ctl_wr_i,
  .ret_restore_i, .fetch_o, .ctl_o, .state_output_pin_o, .exception_link_reg_o, .saved_status_word_o, .locked_o);

/* test/tb_top.sv */
// Self-checking bench for the exception unit
`timescale 1ns/10ps
module tb_top;
  import exc_pkg::*;
  logic ref_clk_i = 1'b0, nrst_i = 1'b0, ff = 1'b0, fn = 1'b0, sy = 1'b1, ie = 1'b0;
  logic da = 1'b0, pa = 1'b0, ud = 1'b0, sw = 1'b0, bl = 1'b0, wr = 1'b0, rr = 1'b0;
  logic [7:0] wd = 8'h00, sv;
  logic [31:0] pc = 32'h0000_0000, rl = 32'h0000_0000, lnk, last_pc, bl_pc;
  logic fq_n, nq_n, pin, lk;
  pc_evt_t fe;
  ctl_t ctl;
  int seed = 32'h0000_18d6;
  int miscompares = 0;
  int check_count = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    pc <= $random(seed) & 32'hFFFF_FFFC;
    ie <= $random(seed);
  end
  irq_src_model i_src (.ref_clk_i(ref_clk_i), .fire_fast_i(ff), .fire_normal_i(fn), .fast_request_n_o(fq_n),
    .normal_request_n_o(nq_n));
  exc_unit i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .fast_request_n_i(fq_n), .normal_request_n_i(nq_n),
    .sync_select_input_i(sy), .insn_end_i(ie), .pc_i(pc), .data_abort_i(da), .prefetch_abort_i(pa),
    .undefined_opcode_trap_i(ud), .software_trap_i(sw), .branch_with_link_i(bl), .ctl_wr_i(wr), .ctl_wdata_i(wd),
    .ret_restore_i(rr), .ret_link_i(rl), .fetch_o(fe), .ctl_o(ctl), .state_output_pin_o(pin),
    .exception_link_reg_o(lnk), .saved_status_word_o(sv), .locked_o(lk));
  task automatic end_sim();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Kinds: 0 data abort, 1 prefetch abort, 2 undefined, 3 trap, 4 fast+normal, 5 normal
  task automatic take(input int k);
    logic [31:0] p, v, o;
    logic [4:0] m;
    logic [7:0] old;
    int n;
    case (k)
      0: begin v = 32'h0000_0010; m = 5'h17; end
      1: begin v = 32'h0000_000C; m = 5'h17; end
      2: begin v = 32'h0000_0004; m = 5'h1B; end
      3: begin v = 32'h0000_0008; m = 5'h13; end
      4: begin v = 32'h0000_001C; m = 5'h11; end
      default: begin v = 32'h0000_0018; m = 5'h12; end
    endcase
    o = (k == 0) ? 32'h0000_0008 : 32'h0000_0004;
    old = ctl;
    n = 0;
    @(posedge ref_clk_i);
    case (k)
      0: da <= 1'b1;
      1: pa <= 1'b1;
      2: ud <= 1'b1;
      3: sw <= 1'b1;
      4: {ff, fn} <= 2'h3;
      default: fn <= 1'b1;
    endcase
    #1;
    // Remember the address seen at each edge; the last one is the taken edge
    do begin
      p = pc;
      @(posedge ref_clk_i);
      {da, pa, ud, sw} <= 4'h0;
      #1;
      n++;
    end while (fe.valid !== 1'b1 && n < 40);
    last_pc = p;
    if (n >= 40) begin
      miscompares++;
      end_sim();
    end
    chk(fe.pc, v);
    @(posedge ref_clk_i);
    {ff, fn} <= 2'h0;
    #1;
    chk(ctl, {1'b1, old[6] | (k == 4), 1'b0, m});
    chk(lnk, p + o);
    chk(sv, old);
    chk(pin, 1'b0);
  endtask
  // Handler return offset: data abort 8, trap and undefined 0, the others 4
  function automatic logic [31:0] back_ofs(input int k);
    back_ofs = (k == 0) ? 32'h0000_0008 : (k == 2 || k == 3) ? 32'h0000_0000 : 32'h0000_0004;
  endfunction
  task automatic ret(input logic [7:0] exp, input int k);
    logic [31:0] to;
    // Idle first so a released request has left the synchroniser
    repeat (4) @(posedge ref_clk_i);
    to = lnk - back_ofs(k);
    rr <= 1'b1;
    rl <= to;
    @(posedge ref_clk_i);
    rr <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk(ctl, exp);
    chk(fe.pc, last_pc + ((k == 2 || k == 3) ? 32'h0000_0004 : 32'h0000_0000));
  endtask
  task automatic wrc(input logic [7:0] d);
    @(posedge ref_clk_i);
    wr <= 1'b1;
    wd <= d;
    @(posedge ref_clk_i);
    wr <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    chk(ctl, 8'hD3);
    chk(fe.pc, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      take(k);
      ret(8'hD3, k);
    end
    wrc(8'h13);
    chk(ctl, 8'h13);
    take(4);
    ret(8'h13, 4);
    take(5);
    ret(8'h13, 5);
    @(posedge ref_clk_i);
    sy <= 1'b0;
    take(4);
    ret(8'h13, 4);
    @(posedge ref_clk_i);
    sy <= 1'b1;
    wrc(8'hD3);
    @(posedge ref_clk_i);
    bl <= 1'b1;
    #1;
    bl_pc = pc;
    @(posedge ref_clk_i);
    bl <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk(lnk, bl_pc + 32'h0000_0004);
    @(posedge ref_clk_i);
    {ff, fn} <= 2'h3;
    repeat (12) begin
      @(posedge ref_clk_i);
      #1;
      chk(fe.valid, 1'b0);
    end
    @(posedge ref_clk_i);
    {ff, fn} <= 2'h0;
    wrc(8'h10);
    wrc(8'h1F);
    chk(ctl, 8'h10);
    take(3);
    wrc(8'h1A);
    chk(lk, 1'b1);
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    chk(lk, 1'b0);
    chk(ctl, 8'hD3);
    end_sim();
  end
endmodule // tb_top
